// ### design/pbx_dir_ctl.v
// Purpose: direction control and parallel poll logic of one extender unit
// Assumes: all bus and link inputs asynchronous, true = asserted
// Notes:   bus lines are handled as asserted levels; drivers outside
`include "pbx_map.vh"
module pbx_dir_ctl (
	input  wire                    sys_clk_in,
	input  wire                    nrst_in,
	input  wire [`PBX_CFG_WIDTH-1:0] config_switch_bank_in,
	input  wire                    bus_ifc_in,
	input  wire                    bus_atn_in,
	input  wire                    bus_eoi_in,
	input  wire                    bus_dav_in,
	input  wire [`PBX_PPR_W-1:0]   bus_dio_in,
	input  wire                    lnk_ifc_in,
	input  wire                    lnk_atn_in,
	input  wire                    lnk_eoi_in,
	input  wire                    lnk_dav_in,
	input  wire                    lnk_pp_hs_in,
	input  wire [`PBX_PPR_W-1:0]   lnk_ppr_in,
	output reg                     local_sysctl_state_out,
	output reg                     remote_sysctl_state_out,
	output reg                     local_active_ctl_state_out,
	output reg                     remote_active_ctl_state_out,
	output reg                     local_source_state_out,
	output reg                     remote_source_state_out,
	output wire                    ifc_ren_to_link_out,
	output wire                    atn_to_link_out,
	output wire                    srq_to_bus_out,
	output wire                    dav_dio_to_link_out,
	output wire                    hs_to_bus_out,
	output reg                     forwarded_attention_out,
	output reg                     forwarded_end_identify_out,
	output reg                     poll_handshake_return_out,
	output reg  [`PBX_PPR_W-1:0]   ppr_to_bus_out,
	output reg                     ppr_drive_en_out,
	output reg  [`PBX_PPR_W-1:0]   ppr_to_link_out,
	output reg                     nrfd_holdoff_out
);
	localparam PP_IDLE = 2'b00;
	localparam PP_WAIT = 2'b01;
	localparam PP_LOAD = 2'b10;
	localparam integer HS_CYC_FULL = `PBX_PP_HS_CYC;
	localparam [`PBX_CNT_W-1:0] HS_CYC = HS_CYC_FULL[`PBX_CNT_W-1:0];

	// Two-flop synchronisers for all asynchronous inputs
	reg [8:0] s1_ff;
	reg [8:0] s2_ff;
	reg [`PBX_CFG_WIDTH-1:0] cfg1_ff;
	reg [`PBX_CFG_WIDTH-1:0] cfg2_ff;
	reg [`PBX_PPR_W-1:0] dio1_ff;
	reg [`PBX_PPR_W-1:0] dio2_ff;
	reg [`PBX_PPR_W-1:0] lppr1_ff;
	reg [`PBX_PPR_W-1:0] lppr2_ff;
	always @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			s1_ff    <= 9'h000;
			s2_ff    <= 9'h000;
			cfg1_ff  <= 8'h00;
			cfg2_ff  <= 8'h00;
			dio1_ff  <= 8'h00;
			dio2_ff  <= 8'h00;
			lppr1_ff <= 8'h00;
			lppr2_ff <= 8'h00;
		end else begin
			s1_ff    <= {lnk_pp_hs_in, lnk_dav_in, lnk_eoi_in, lnk_atn_in, lnk_ifc_in,
				bus_dav_in, bus_eoi_in, bus_atn_in, bus_ifc_in};
			s2_ff    <= s1_ff;
			cfg1_ff  <= config_switch_bank_in;
			cfg2_ff  <= cfg1_ff;
			dio1_ff  <= bus_dio_in;
			dio2_ff  <= dio1_ff;
			lppr1_ff <= lnk_ppr_in;
			lppr2_ff <= lppr1_ff;
		end
	end

	wire b_ifc = s2_ff[0];
	wire b_atn = s2_ff[1];
	wire b_eoi = s2_ff[2];
	wire b_dav = s2_ff[3];
	wire l_ifc = s2_ff[4];
	wire l_atn = s2_ff[5];
	wire l_eoi = s2_ff[6];
	wire l_dav = s2_ff[7];
	wire l_hs  = s2_ff[8];
	wire talk_only_mode = cfg2_ff[`PBX_CFG_MODE_BIT];
	wire controller_capable_mode = ~talk_only_mode;
	wire buffered_ppr = ~cfg2_ff[`PBX_CFG_PPR_BIT];

	// Previous levels for edge detection (second stage only)
	reg b_ifc_q_ff, b_atn_q_ff, b_dav_q_ff, l_ifc_q_ff, l_atn_q_ff, l_dav_q_ff;
	always @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			{b_ifc_q_ff, b_atn_q_ff, b_dav_q_ff} <= 3'h0;
			{l_ifc_q_ff, l_atn_q_ff, l_dav_q_ff} <= 3'h0;
		end else begin
			{b_ifc_q_ff, b_atn_q_ff, b_dav_q_ff} <= {b_ifc, b_atn, b_dav};
			{l_ifc_q_ff, l_atn_q_ff, l_dav_q_ff} <= {l_ifc, l_atn, l_dav};
		end
	end

	// A leading edge is ignored when the twin already drives that line to us
	wire b_ifc_rise = b_ifc & ~b_ifc_q_ff & ~remote_sysctl_state_out;
	wire l_ifc_rise = l_ifc & ~l_ifc_q_ff;
	wire b_atn_rise = b_atn & ~b_atn_q_ff & ~remote_active_ctl_state_out;
	wire l_atn_rise = l_atn & ~l_atn_q_ff;
	wire b_dav_rise = b_dav & ~b_dav_q_ff & ~remote_source_state_out;
	wire l_dav_rise = l_dav & ~l_dav_q_ff;
	wire atn_change = (b_atn != b_atn_q_ff) & ~remote_active_ctl_state_out;
	wire ctl_found  = local_sysctl_state_out | remote_sysctl_state_out;
	wire ac_found   = local_active_ctl_state_out | remote_active_ctl_state_out;
	reg  [1:0] pp_st_ff;
	wire poll_busy  = (pp_st_ff != PP_IDLE);
	reg  dir_fixed_ff;

	// Controller and source tracking; local and remote exclusive per function
	always @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			local_sysctl_state_out      <= 1'b0;
			remote_sysctl_state_out     <= 1'b0;
			local_active_ctl_state_out  <= 1'b0;
			remote_active_ctl_state_out <= 1'b0;
			local_source_state_out      <= 1'b0;
			remote_source_state_out     <= 1'b0;
			dir_fixed_ff                <= 1'b0;
		end else if (talk_only_mode) begin
			local_sysctl_state_out      <= 1'b0;
			remote_sysctl_state_out     <= 1'b0;
			local_active_ctl_state_out  <= 1'b0;
			remote_active_ctl_state_out <= 1'b0;
			// First DAV from either side fixes the direction for good
			if (!dir_fixed_ff && b_dav_rise) begin
				local_source_state_out <= 1'b1;
				dir_fixed_ff           <= 1'b1;
			end else if (!dir_fixed_ff && l_dav_rise) begin
				remote_source_state_out <= 1'b1;
				dir_fixed_ff            <= 1'b1;
			end
		end else begin
			// System controller: IFC first, whoever pulses it last owns it, but a bus pulse is ignored while the twin owns it
			if (b_ifc_rise) begin
				local_sysctl_state_out  <= 1'b1;
				remote_sysctl_state_out <= 1'b0;
			end else if (l_ifc_rise) begin
				local_sysctl_state_out  <= 1'b0;
				remote_sysctl_state_out <= 1'b1;
			end
			// Active controller only after system controller is known
			if (ctl_found && b_atn_rise) begin
				local_active_ctl_state_out  <= 1'b1;
				remote_active_ctl_state_out <= 1'b0;
			end else if (ctl_found && l_atn_rise) begin
				local_active_ctl_state_out  <= 1'b0;
				remote_active_ctl_state_out <= 1'b1;
			end
			// Source cleared on ATN change or poll; DAV takes it only while the other side is quiet
			if (!ac_found || atn_change || poll_busy) begin
				local_source_state_out  <= 1'b0;
				remote_source_state_out <= 1'b0;
			end else if (b_dav_rise && !l_dav && !l_atn) begin
				local_source_state_out  <= 1'b1;
				remote_source_state_out <= 1'b0;
			end else if (l_dav_rise && !b_dav && !b_atn) begin
				local_source_state_out  <= 1'b0;
				remote_source_state_out <= 1'b1;
			end
		end
	end

	// Line directions derived from the tracked states
	assign ifc_ren_to_link_out = local_sysctl_state_out;
	assign atn_to_link_out     = local_active_ctl_state_out;
	assign srq_to_bus_out      = local_active_ctl_state_out;
	assign dav_dio_to_link_out = local_source_state_out;
	assign hs_to_bus_out       = local_source_state_out;

	// Parallel poll: identify is ATN and EOI together, in either order
	wire idy_local = b_atn & b_eoi & controller_capable_mode;
	wire idy_remote = l_atn & l_eoi & controller_capable_mode;
	reg  [`PBX_PPR_W-1:0] ppr_reg_ff;
	reg  [`PBX_CNT_W-1:0] hs_cnt_ff;

	// Local poll sequencer; forwarded lines held until response returns and local identify ends
	always @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			pp_st_ff                   <= PP_IDLE;
			forwarded_attention_out    <= 1'b0;
			forwarded_end_identify_out <= 1'b0;
			ppr_reg_ff                 <= 8'h00;
		end else begin
			case (pp_st_ff)
			PP_IDLE: begin
				if (idy_local && !idy_remote) begin
					forwarded_attention_out    <= 1'b1;
					forwarded_end_identify_out <= 1'b1;
					pp_st_ff                   <= PP_WAIT;
				end
			end
			PP_WAIT: begin
				// Both the response and the end of local identify are needed
				if (l_hs && !idy_local) begin
					forwarded_attention_out    <= 1'b0;
					forwarded_end_identify_out <= 1'b0;
					ppr_reg_ff                 <= lppr2_ff;
					pp_st_ff                   <= PP_LOAD;
				end
			end
			PP_LOAD: begin
				if (!l_hs) begin
					pp_st_ff <= PP_IDLE;
				end
			end
			default: begin
				pp_st_ff <= PP_IDLE;
			end
			endcase
		end
	end

	// Response to local bus: register in buffered mode, link data otherwise
	always @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			ppr_to_bus_out   <= 8'h00;
			ppr_drive_en_out <= 1'b0;
			nrfd_holdoff_out <= 1'b0;
		end else begin
			// Buffered: three cycles after identify on the bus, well inside the response window
			ppr_drive_en_out <= idy_local && (buffered_ppr || l_hs);
			ppr_to_bus_out   <= buffered_ppr ? ppr_reg_ff : lppr2_ff;
			nrfd_holdoff_out <= idy_local | poll_busy;
		end
	end

	// Remote side: replay poll on our bus, return handshake after 2 us
	always @(posedge sys_clk_in) begin
		if (!nrst_in) begin
			hs_cnt_ff                 <= 10'h000;
			poll_handshake_return_out <= 1'b0;
			ppr_to_link_out           <= 8'h00;
		end else if (!idy_remote) begin
			hs_cnt_ff                 <= 10'h000;
			poll_handshake_return_out <= 1'b0;
		end else if (hs_cnt_ff < HS_CYC) begin
			hs_cnt_ff <= hs_cnt_ff + 10'h001;
		end else begin
			poll_handshake_return_out <= 1'b1;
			ppr_to_link_out           <= dio2_ff;
		end
	end
endmodule

// ### design/pbx_map.vh
// Purpose: constants for the bus extender direction control block
// Assumes: 250 MHz system clock
// Notes:   times in ns, counts by integer division: response count truncated, handshake count rounded up
`ifndef PBX_MAP_VH
`define PBX_MAP_VH
`define PBX_CLK_PERIOD_NS     4
`define PBX_CFG_MODE_BIT      0
`define PBX_CFG_PPR_BIT       2
`define PBX_CFG_WIDTH         8
`define PBX_IDY_RESP_NS       200
`define PBX_IDY_RESP_CYC      (`PBX_IDY_RESP_NS / `PBX_CLK_PERIOD_NS)
`define PBX_PP_HS_NS          2000
`define PBX_PP_HS_CYC         ((`PBX_PP_HS_NS + `PBX_CLK_PERIOD_NS - 1) / `PBX_CLK_PERIOD_NS)
`define PBX_CNT_W             10
`define PBX_PPR_W             8
`endif

// ### tb/pbx_dir_ctl_sva.sv
// Purpose: ownership and poll timing checks on one extender unit
// Assumes: outputs follow the hand-over timing of the unit
// Notes:   windows allow for the two-flop input synchronisers
`include "pbx_map.vh"
module pbx_dir_ctl_sva (
	input logic sys_clk_in, nrst_in, bus_ifc_in, bus_atn_in, bus_eoi_in,
	input logic [`PBX_CFG_WIDTH-1:0] config_switch_bank_in,
	input logic lnk_ifc_in, lnk_atn_in, lnk_eoi_in, lnk_pp_hs_in, nrfd_holdoff_out,
	input logic local_sysctl_state_out, remote_sysctl_state_out, local_active_ctl_state_out,
	input logic remote_active_ctl_state_out, local_source_state_out, remote_source_state_out,
	input logic forwarded_attention_out, forwarded_end_identify_out, poll_handshake_return_out, ppr_drive_en_out
);
	logic [9:0] idy_cnt_ff;
	default clocking dcb @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);
	// Link identify length; 10 bits cover a 2 us wait
	always_ff @(posedge sys_clk_in)
		idy_cnt_ff <= (nrst_in && lnk_atn_in && lnk_eoi_in) ? idy_cnt_ff + 10'h001 : 10'h000;
	AST_IFC_LOC: assert property ($rose(bus_ifc_in) && !config_switch_bank_in[0] && !remote_sysctl_state_out
		|-> ##[1:4] local_sysctl_state_out) else $error("local sysctl not taken");
	AST_IFC_REM: assert property ($rose(lnk_ifc_in) && !config_switch_bank_in[0]
		|-> ##[1:4] remote_sysctl_state_out && !local_sysctl_state_out) else $error("sysctl not handed over");
	AST_QUIET: assert property ($rose(local_sysctl_state_out)
		|-> $past(bus_ifc_in, 2) || $past(bus_ifc_in, 3)) else $error("sysctl without ifc");
	AST_TALK_IDLE: assert property ($past(config_switch_bank_in[0], 4) && config_switch_bank_in[0]
		|-> !(local_sysctl_state_out || remote_sysctl_state_out || local_active_ctl_state_out
		|| remote_active_ctl_state_out)) else $error("controller state in talk-only");
	AST_ONE_OWNER: assert property (!(local_sysctl_state_out && remote_sysctl_state_out)
		&& !(local_active_ctl_state_out && remote_active_ctl_state_out)
		&& !(local_source_state_out && remote_source_state_out)) else $error("both sides own a state");
	AST_BUF_RESP: assert property ($rose(bus_atn_in && bus_eoi_in) && !config_switch_bank_in[0]
		&& !config_switch_bank_in[2] && !lnk_atn_in && !forwarded_attention_out && !nrfd_holdoff_out
		|-> ##[1:50] ppr_drive_en_out) else $error("buffered answer late");
	AST_FWD_HOLD: assert property (forwarded_attention_out && forwarded_end_identify_out && !lnk_pp_hs_in
		|=> forwarded_attention_out && forwarded_end_identify_out) else $error("forwarded poll dropped early");
	AST_HS_TIME: assert property ($rose(poll_handshake_return_out)
		|-> idy_cnt_ff >= 10'h1ef && idy_cnt_ff <= 10'h1fe) else $error("poll handshake off time");
endmodule
bind pbx_dir_ctl pbx_dir_ctl_sva pbx_dir_ctl_sva_inst (.*);

// ### tb/pbx_dir_ctl_tb_top.sv
// Purpose: self-checking bench for one extender unit
// Assumes: bench stands in for local bus and twin link lines
// Notes:   inputs change 1 ns after the rising edge
module pbx_dir_ctl_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk_in = 1'b0, nrst_in = 1'b0, bus_ifc_in = 1'b0, bus_atn_in = 1'b0, bus_eoi_in = 1'b0, bus_dav_in = 1'b0;
	logic lnk_ifc_in = 1'b0, lnk_atn_in = 1'b0, lnk_eoi_in = 1'b0, lnk_dav_in = 1'b0;
	logic [7:0] config_switch_bank_in = 8'h00, bus_dio_in = 8'h00, resp = 8'h00;
	// Driven only by the twin model
	logic lnk_pp_hs_in;
	logic [7:0] lnk_ppr_in;
	logic [7:0] ppr_to_bus_out, ppr_to_link_out;
	logic local_sysctl_state_out, remote_sysctl_state_out, local_active_ctl_state_out, remote_active_ctl_state_out;
	logic local_source_state_out, remote_source_state_out, ifc_ren_to_link_out, atn_to_link_out, srq_to_bus_out;
	logic dav_dio_to_link_out, hs_to_bus_out, forwarded_attention_out, forwarded_end_identify_out;
	logic poll_handshake_return_out, ppr_drive_en_out, nrfd_holdoff_out;
	int n_mismatch = 0;
	int checks_done = 0;
	// 250 MHz clock
	always #2 sys_clk_in = ~sys_clk_in;
	pbx_dir_ctl pbx_dir_ctl_inst (.*);
	pbx_twin_model #(.HS_DLY(40)) pbx_twin_model_inst (.clk_in(sys_clk_in), .fwd_atn_in(forwarded_attention_out),
		.fwd_eoi_in(forwarded_end_identify_out), .resp_in(resp), .pp_hs_out(lnk_pp_hs_in), .ppr_out(lnk_ppr_in));
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic do_reset(input logic [7:0] cfg);
		nrst_in = 1'b0;
		config_switch_bank_in = cfg;
		step(16);
		nrst_in = 1'b1;
		step(2);
	endtask
	task automatic line(ref logic s, input logic v);
		s = v;
		step(6);
	endtask
	// Controller mode: order of ownership and hand-over
	task automatic t_ctl_order();
		chk("idle", {local_sysctl_state_out, remote_sysctl_state_out}, 8'h00);
		line(bus_atn_in, 1'b1);
		chk("atn first", local_active_ctl_state_out, 8'h00);
		bus_atn_in = 1'b0;
		line(bus_ifc_in, 1'b1);
		bus_ifc_in = 1'b0;
		chk("sysctl", {local_sysctl_state_out, ifc_ren_to_link_out}, 8'h03);
		line(bus_atn_in, 1'b1);
		chk("active", {local_active_ctl_state_out, atn_to_link_out, srq_to_bus_out}, 8'h07);
		line(bus_dav_in, 1'b1);
		chk("source", {local_source_state_out, dav_dio_to_link_out, hs_to_bus_out}, 8'h07);
		bus_dav_in = 1'b0;
		bus_atn_in = 1'b0;
		line(lnk_ifc_in, 1'b1);
		chk("handover", {local_sysctl_state_out, remote_sysctl_state_out, ifc_ren_to_link_out}, 8'h02);
		lnk_ifc_in = 1'b0;
		line(lnk_atn_in, 1'b1);
		chk("ac handover", {local_active_ctl_state_out, remote_active_ctl_state_out, srq_to_bus_out}, 8'h02);
		line(lnk_dav_in, 1'b1);
		chk("remote src", {local_source_state_out, remote_source_state_out, hs_to_bus_out}, 8'h02);
		lnk_dav_in = 1'b0;
		lnk_atn_in = 1'b0;
		$display("t_ctl_order done");
	endtask
	// One local poll; buffered drops identify before the twin answers
	task automatic poll(input logic [7:0] exp_bus, input logic bufd);
		bus_eoi_in = 1'b1;
		line(bus_atn_in, 1'b1);
		step(6);
		chk("drive early", ppr_drive_en_out, {7'h00, bufd});
		if (bufd) begin
			chk("stored", ppr_to_bus_out, exp_bus);
			bus_eoi_in = 1'b0;
			line(bus_atn_in, 1'b0);
			chk("fwd held", {forwarded_attention_out, forwarded_end_identify_out, nrfd_holdoff_out}, 8'h07);
		end
		for (int i = 0; i < 200 && !lnk_pp_hs_in; i++) step(1);
		step(6);
		if (!bufd) step(500);
		if (!bufd) chk("direct", ppr_to_bus_out & {8{ppr_drive_en_out}}, resp);
		bus_eoi_in = 1'b0;
		bus_atn_in = 1'b0;
		for (int i = 0; i < 200 && lnk_pp_hs_in; i++) step(1);
		step(6);
		chk("closed", {forwarded_attention_out, ppr_drive_en_out, nrfd_holdoff_out}, 8'h00);
	endtask
	task automatic t_poll_buf();
		resp = 8'h3c;
		poll(8'h00, 1'b1);
		resp = 8'hc3;
		poll(8'h3c, 1'b1);
		$display("t_poll_buf done");
	endtask
	task automatic t_poll_unbuf();
		resp = 8'h5a;
		poll(8'h00, 1'b0);
		$display("t_poll_unbuf done");
	endtask
	// Poll arriving from the twin answered after 2 us
	task automatic t_remote_poll();
		bus_dio_in = 8'h96;
		lnk_eoi_in = 1'b1;
		lnk_atn_in = 1'b1;
		step(495);
		chk("hs early", poll_handshake_return_out, 8'h00);
		step(15);
		chk("hs", poll_handshake_return_out, 8'h01);
		chk("remote resp", ppr_to_link_out, 8'h96);
		lnk_eoi_in = 1'b0;
		line(lnk_atn_in, 1'b0);
		chk("hs end", poll_handshake_return_out, 8'h00);
		$display("t_remote_poll done");
	endtask
	// Talk-only: controller lines dead, first data valid fixes direction
	task automatic t_talk_only();
		bus_ifc_in = 1'b1;
		line(bus_atn_in, 1'b1);
		chk("no ctl", {local_sysctl_state_out, local_active_ctl_state_out, atn_to_link_out}, 8'h00);
		bus_ifc_in = 1'b0;
		bus_atn_in = 1'b0;
		line(bus_dav_in, 1'b1);
		chk("first src", {local_source_state_out, dav_dio_to_link_out}, 8'h03);
		bus_dav_in = 1'b0;
		line(lnk_dav_in, 1'b1);
		chk("src fixed", {local_source_state_out, remote_source_state_out}, 8'h02);
		$display("t_talk_only done");
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		do_reset(8'h00);
		t_ctl_order();
		t_poll_buf();
		do_reset(8'h04);
		t_poll_unbuf();
		t_remote_poll();
		do_reset(8'h01);
		t_talk_only();
		complete_run();
	end
	// Watchdog, several times the expected run
	initial begin
		#40us;
		n_mismatch++;
		complete_run();
	end
endmodule

// ### tb/pbx_twin_model.sv
// Purpose: twin unit answering a poll forwarded over the link
// Assumes: forwarded poll lines are levels on the bench clock
// Notes:   handshake delay shortened to keep the run brief
module pbx_twin_model #(parameter int HS_DLY = 40) (
	input  wire logic       clk_in,
	input  wire logic       fwd_atn_in,
	input  wire logic       fwd_eoi_in,
	input  wire logic [7:0] resp_in,
	output logic            pp_hs_out,
	output logic [7:0]      ppr_out
);
	timeunit 1ns;
	timeprecision 100ps;
	int cnt_ff = 0;
	// Lines idle low until the first edge, so the unit never syncs an unknown
	initial begin
		pp_hs_out = 1'b0;
		ppr_out   = 8'h00;
	end
	// Answer after settling; released data lines never keep their value
	always @(posedge clk_in) begin
		if (fwd_atn_in && fwd_eoi_in) begin
			cnt_ff <= cnt_ff + 1;
			if (cnt_ff == HS_DLY) begin
				pp_hs_out <= #1 1'b1;
				ppr_out <= #1 resp_in;
			end
		end else begin
			cnt_ff <= 0;
			pp_hs_out <= #1 1'b0;
			ppr_out <= #1 ~ppr_out;
		end
	end
endmodule
